// file: tmo_consts.svh
// Register offsets, field positions, reset values and timing counts of the timer
`ifndef TMO_CONSTS_SVH
`define TMO_CONSTS_SVH

// Byte offsets on the register bus
`define TMO_OFS_CTRL 8'h00
`define TMO_OFS_CNT_LO 8'h04
`define TMO_OFS_CNT_HI 8'h08
`define TMO_OFS_GSEL 8'h0C
`define TMO_OFS_FLAG 8'h10
`define TMO_OFS_PEN 8'h14
`define TMO_OFS_CORE 8'h18
`define TMO_OFS_LCD 8'h1C

// Control register fields
`define TMO_B_POL 7
`define TMO_B_GEN 6
`define TMO_B_PS_HI 5
`define TMO_B_PS_LO 4
`define TMO_B_LPOSC 3
`define TMO_B_ASYNC 2
`define TMO_B_EXT 1
`define TMO_B_RUN 0

// Gate select register fields
`define TMO_B_GSS 1
`define TMO_B_COMP_TWO_SYNC 0

// Core interrupt control fields
`define TMO_B_GLOBAL_EN 1
`define TMO_B_PERIPH_EN 0

// Clock output control fields
`define TMO_B_LCD_RUN_SLEEP 1
`define TMO_B_LCD_EN 0

// Reset values
`define TMO_RST_CTRL 8'h00
`define TMO_RST_GSEL 2'h2
`define TMO_RST_CORE 2'h0
`define TMO_RST_LCD 2'h0

// Counter limits
`define TMO_CNT_MAX 16'hFFFF
`define TMO_CNT_ZERO 16'h0000

// Oscillator clocks per instruction cycle, minus one
`define TMO_INSTR_DIV_LAST 2'h3

`endif

// file: tmo_far_side.sv
// External counter clock source model
`timescale 1ns/1ps
module tmo_far_side (
	input wire logic go_i,
	input wire logic [3:0] n_i,
	output logic ext_o
);
	// Burst of n rising edges, unrelated to the core clock; low between bursts
	initial begin
		ext_o = 1'b0;
		forever begin
			@(posedge go_i);
			repeat (n_i) begin
				#730 ext_o = 1'b1;
				#730 ext_o = 1'b0;
			end
		end
	end
endmodule

// file: tmo_pkg.sv
// Types shared by the timer files
package tmo_pkg;

	typedef logic [31:0] tmo_word_t;
	typedef logic [7:0] tmo_byte_t;

	// Qualifier that holds off the first rising edge of the external clock
	typedef enum logic [0:0] {
		TMO_ARM_WAIT_FALL = 1'b0,
		TMO_ARM_READY = 1'b1
	} tmo_arm_t;

endpackage

// file: tmo_prescaler.sv
// Divide-by-1/2/4/8 prescaler with clear
`timescale 1ns/1ps
module tmo_prescaler (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic tick_i,
	input wire logic clear_i,
	input wire logic [1:0] sel_i,
	output logic pulse_o
);

	logic [2:0] cnt_r;
	logic [2:0] last;

	// Terminal count of the selected ratio
	always_comb begin
		unique case (sel_i)
			2'h0: last = 3'h0;
			2'h1: last = 3'h1;
			2'h2: last = 3'h3;
			2'h3: last = 3'h7;
		endcase
	end

	assign pulse_o = tick_i & (cnt_r >= last);

	// Hidden count; a clear drops any partial division
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt_r <= 3'h0;
		end else if (clear_i) begin
			cnt_r <= 3'h0;
		end else if (pulse_o) begin
			cnt_r <= 3'h0;
		end else if (tick_i) begin
			cnt_r <= cnt_r + 3'h1;
		end
	end

endmodule

// file: tmo_sync2.sv
// Two flip-flop synchroniser for one pin level
`timescale 1ns/1ps
module tmo_sync2 (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic d_i,
	output logic q_o
);

	logic meta_r;

	// First stage is read only by the second
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			meta_r <= 1'b0;
			q_o <= 1'b0;
		end else begin
			meta_r <= d_i;
			q_o <= meta_r;
		end
	end

endmodule

// file: tmo_timer.sv
// Gated sixteen-bit timer and counter with an AHB-Lite register slave
//
// Contract
// R1: Each byte read of the counter returns one coherent sample.
// R2: Software should stop the counter before writing a counter byte.
// R3: Gate comes from the gate pin or comparator two, chosen by a bit.
// R4: Gate enable restricts counting to gate-active time only while running.
// R5: Gate polarity inverts the gate whatever its source.
// R6: Counter wraps all-ones to zero and sets the overflow flag.
// R7: Interrupt needs overflow, peripheral and global enables all set.
// R8: Software clears the overflow flag; hardware never does.
// R9: Software should clear counter and flag before enabling the interrupt.
// R10: In Sleep only asynchronous external counting keeps running.
// R11: In Sleep an enabled overflow wakes the core; global enable vectors it. Here wake-up also needs the run bit set.
// R12: Low-power oscillator clock feeds LCD, optionally kept running in Sleep.
// R13: External mode needs a falling edge before the first counted rising edge.
// R14: Prescale field divides by 1, 2, 4 or 8.
// R15: Oscillator enable works only with internal oscillator without clock out.
// R16: Sync bit chooses unsynchronised or synchronised external clock.
// R17: Clock source bit picks external pin rising edge or instruction clock.
// R18: Run bit lets the counter advance; cleared it holds its value.
// R19: Counter bytes are not reset and keep their contents across resets.
// R20: Any write to a counter byte clears the prescaler.
// R21: Overflow flag sets on every wrap regardless of enables.
//
// Chosen here: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`include "tmo_consts.svh"
module tmo_timer (
	input wire logic CLK_I,
	input wire logic NRST_I,
	input wire logic HSEL_I,
	input wire tmo_pkg::tmo_word_t HADDR_I,
	input wire logic [1:0] HTRANS_I,
	input wire logic HWRITE_I,
	input wire logic [2:0] HSIZE_I,
	input wire tmo_pkg::tmo_word_t HWDATA_I,
	input wire logic HREADY_I,
	output logic HREADYOUT_O,
	output tmo_pkg::tmo_word_t HRDATA_O,
	output logic HRESP_O,
	input wire logic EXT_CLOCK_PIN_I,
	input wire logic GATE_PIN_I,
	input wire logic COMP_TWO_OUTPUT_I,
	input wire logic SLEEP_I,
	input wire logic INTOSC_NO_CLKOUT_I,
	output logic IRQ_O,
	output logic WAKE_O,
	output logic LP_OSC_EN_O,
	output logic LCD_CLK_O
);
	import tmo_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Declarations

	tmo_byte_t timer_one_control_r;
	logic [15:0] count_r;
	logic [1:0] comparator_gate_select_r;
	logic overflow_flag_r;
	logic overflow_enable_r;
	logic [1:0] core_interrupt_control_r;
	logic [1:0] lcd_clock_control_r;

	logic wr_pend_r;
	logic rd_pend_r;
	logic [7:0] addr_r;
	logic accept;
	tmo_word_t rd_val;

	logic wr_lo;
	logic wr_hi;
	logic wr_cnt;

	logic ext_s;
	logic gate_s;
	logic comp_s;
	logic ext_d_r;
	logic ext_rise;
	logic ext_fall;
	tmo_arm_t arm_r;
	logic run_d_r;
	logic ext_edge;
	logic sync_pend_r;

	logic [1:0] instr_div_r;
	logic instr_tick;
	logic src_tick;
	logic gate_raw;
	logic gate_active;
	logic sleep_ok;
	logic count_en;
	logic inc;
	logic wrap;

	logic gate_polarity;
	logic gate_enable;
	logic [1:0] prescale_select;
	logic low_power_osc_enable;
	logic sync_control;
	logic clock_source_select;
	logic run_bit;
	logic gate_source_select;
	logic periph_int_en;
	logic global_int_en;

	////////////////////////////////////////////////////////////////////////
	// Control field views

	assign gate_polarity = timer_one_control_r[`TMO_B_POL];
	assign gate_enable = timer_one_control_r[`TMO_B_GEN];
	assign prescale_select = timer_one_control_r[`TMO_B_PS_HI:`TMO_B_PS_LO];
	assign low_power_osc_enable = timer_one_control_r[`TMO_B_LPOSC];
	assign sync_control = timer_one_control_r[`TMO_B_ASYNC];
	assign clock_source_select = timer_one_control_r[`TMO_B_EXT];
	assign run_bit = timer_one_control_r[`TMO_B_RUN];
	assign gate_source_select = comparator_gate_select_r[`TMO_B_GSS];
	assign periph_int_en = core_interrupt_control_r[`TMO_B_PERIPH_EN];
	assign global_int_en = core_interrupt_control_r[`TMO_B_GLOBAL_EN];

	////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave

	// Address phase taken only when the bus is ready
	assign accept = HSEL_I & HTRANS_I[1] & HREADY_I;

	// Writes are zero-wait; reads take one wait so a prior write is seen
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			addr_r <= 8'h00;
			HREADYOUT_O <= 1'b1;
		end else begin
			wr_pend_r <= accept & HWRITE_I;
			rd_pend_r <= accept & ~HWRITE_I;
			HREADYOUT_O <= ~(accept & ~HWRITE_I);
			if (accept) begin
				addr_r <= {HADDR_I[7:2], 2'h0};
			end
		end
	end

	// Error response is never used
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			HRESP_O <= 1'b0;
		end else begin
			HRESP_O <= 1'b0;
		end
	end

	// Read mux; unmapped words read zero
	always_comb begin
		rd_val = 32'h0000_0000;
		unique case (addr_r)
			`TMO_OFS_CTRL: rd_val[7:0] = timer_one_control_r;
			`TMO_OFS_CNT_LO: rd_val[7:0] = count_r[7:0]; // [R1]
			`TMO_OFS_CNT_HI: rd_val[7:0] = count_r[15:8]; // [R1]
			`TMO_OFS_GSEL: rd_val[1:0] = comparator_gate_select_r;
			`TMO_OFS_FLAG: rd_val[0] = overflow_flag_r;
			`TMO_OFS_PEN: rd_val[0] = overflow_enable_r;
			`TMO_OFS_CORE: rd_val[1:0] = core_interrupt_control_r;
			`TMO_OFS_LCD: rd_val[1:0] = lcd_clock_control_r;
			default: rd_val = 32'h0000_0000;
		endcase
	end

	// Whole-clock sample, so a byte never mixes two counts
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			HRDATA_O <= 32'h0000_0000;
		end else if (rd_pend_r) begin
			HRDATA_O <= rd_val; // [R1]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Configuration registers

	// Plain read/write configuration words
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			timer_one_control_r <= `TMO_RST_CTRL;
			comparator_gate_select_r <= `TMO_RST_GSEL;
			overflow_enable_r <= 1'b0;
			core_interrupt_control_r <= `TMO_RST_CORE;
			lcd_clock_control_r <= `TMO_RST_LCD;
		end else if (wr_pend_r) begin
			unique case (addr_r)
				`TMO_OFS_CTRL: timer_one_control_r <= HWDATA_I[7:0];
				`TMO_OFS_GSEL: comparator_gate_select_r <= HWDATA_I[1:0]; // [R3]
				`TMO_OFS_PEN: overflow_enable_r <= HWDATA_I[0];
				`TMO_OFS_CORE: core_interrupt_control_r <= HWDATA_I[1:0];
				`TMO_OFS_LCD: lcd_clock_control_r <= HWDATA_I[1:0];
				default: ;
			endcase
		end
	end

	assign wr_lo = wr_pend_r & (addr_r == `TMO_OFS_CNT_LO);
	assign wr_hi = wr_pend_r & (addr_r == `TMO_OFS_CNT_HI);
	assign wr_cnt = wr_lo | wr_hi;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	tmo_sync2 u_sync_ext (
		.clk_i(CLK_I),
		.nrst_i(NRST_I),
		.d_i(EXT_CLOCK_PIN_I),
		.q_o(ext_s)
	);

	tmo_sync2 u_sync_gate (
		.clk_i(CLK_I),
		.nrst_i(NRST_I),
		.d_i(GATE_PIN_I),
		.q_o(gate_s)
	);

	tmo_sync2 u_sync_comp (
		.clk_i(CLK_I),
		.nrst_i(NRST_I),
		.d_i(COMP_TWO_OUTPUT_I),
		.q_o(comp_s)
	);

	////////////////////////////////////////////////////////////////////////
	// Clock sources

	// Instruction clock: one tick per four oscillator clocks, halted in Sleep
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			instr_div_r <= 2'h0;
		end else begin
			instr_div_r <= instr_div_r + 2'h1;
		end
	end

	assign instr_tick = (instr_div_r == `TMO_INSTR_DIV_LAST) & ~SLEEP_I;

	// Edge detect on the synchronised pin
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			ext_d_r <= 1'b0;
			run_d_r <= 1'b0;
		end else begin
			ext_d_r <= ext_s;
			run_d_r <= run_bit;
		end
	end

	assign ext_rise = ext_s & ~ext_d_r;
	assign ext_fall = ~ext_s & ext_d_r;

	// Arming: reset, counter write or enable wait for a falling edge
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			arm_r <= TMO_ARM_WAIT_FALL;
		end else if (wr_cnt || (run_bit && !run_d_r)) begin
			arm_r <= TMO_ARM_WAIT_FALL; // [R13]
		end else begin
			unique case (arm_r)
				TMO_ARM_WAIT_FALL: if (ext_fall) begin
					arm_r <= TMO_ARM_READY; // [R13]
				end
				TMO_ARM_READY: arm_r <= TMO_ARM_READY;
			endcase
		end
	end

	// A rising edge counts only once armed
	assign ext_edge = ext_rise & (arm_r == TMO_ARM_READY); // [R13] [R17]

	// Synchronised mode defers the edge to the next instruction tick;
	// the trade-off is up to three clocks of latency per count
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			sync_pend_r <= 1'b0;
		end else if (instr_tick || wr_cnt) begin
			sync_pend_r <= 1'b0;
		end else if (ext_edge) begin
			sync_pend_r <= 1'b1; // [R16]
		end
	end

	// Source pick; sync bit matters only for the external clock
	always_comb begin
		if (!clock_source_select) begin
			src_tick = instr_tick; // [R17]
		end else if (sync_control) begin
			src_tick = ext_edge; // [R16]
		end else begin
			src_tick = instr_tick & (sync_pend_r | ext_edge); // [R16]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Gate and count enable

	assign gate_raw = gate_source_select ? comp_s : gate_s; // [R3]
	assign gate_active = gate_polarity ? gate_raw : ~gate_raw; // [R5]

	// Only the asynchronous external counter survives Sleep
	assign sleep_ok = ~SLEEP_I | (clock_source_select & sync_control); // [R10]

	// Gate enable is ignored while stopped, since run gates all
	assign count_en = run_bit & (~gate_enable | gate_active) & sleep_ok; // [R4] [R18]

	tmo_prescaler u_presc (
		.clk_i(CLK_I),
		.nrst_i(NRST_I),
		.tick_i(src_tick & count_en),
		.clear_i(wr_cnt), // [R20]
		.sel_i(prescale_select), // [R14]
		.pulse_o(inc)
	);

	assign wrap = inc & (count_r == `TMO_CNT_MAX);

	////////////////////////////////////////////////////////////////////////
	// Counter

	// No reset: contents survive every reset and start unknown.
	// A write racing an increment wins; software must stop the timer first.
	always_ff @(posedge CLK_I) begin
		if (wr_lo) begin
			count_r[7:0] <= HWDATA_I[7:0]; // [R19]
		end else if (wr_hi) begin
			count_r[15:8] <= HWDATA_I[7:0]; // [R19]
		end else if (wrap) begin
			count_r <= `TMO_CNT_ZERO; // [R6]
		end else if (inc) begin
			count_r <= count_r + 16'h0001; // [R18]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Overflow flag and core signalling

	// Set on each wrap, whatever the enables; a set beats a clear
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			overflow_flag_r <= 1'b0;
		end else if (wrap) begin
			overflow_flag_r <= 1'b1; // [R6] [R21]
		end else if (wr_pend_r && (addr_r == `TMO_OFS_FLAG)) begin
			overflow_flag_r <= HWDATA_I[0]; // [R8]
		end
	end

	// Interrupt request and wake-up from the sticky flag
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			IRQ_O <= 1'b0;
			WAKE_O <= 1'b0;
		end else begin
			IRQ_O <= overflow_flag_r & overflow_enable_r & periph_int_en
				& global_int_en; // [R7] [R11]
			WAKE_O <= SLEEP_I & run_bit & overflow_flag_r & overflow_enable_r
				& periph_int_en; // [R11]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Low-power oscillator and LCD clock

	// The oscillator pins carry the crystal clock seen on the external pin
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			LP_OSC_EN_O <= 1'b0;
			LCD_CLK_O <= 1'b0;
		end else begin
			LP_OSC_EN_O <= low_power_osc_enable & INTOSC_NO_CLKOUT_I; // [R15]
			LCD_CLK_O <= LP_OSC_EN_O & lcd_clock_control_r[`TMO_B_LCD_EN] & ext_s
				& (~SLEEP_I | lcd_clock_control_r[`TMO_B_LCD_RUN_SLEEP]); // [R12]
		end
	end

endmodule

// file: tmo_timer_sva.sv
// Port-level checker of the timer's bus timing and status outputs
`timescale 1ns/1ps
module tmo_timer_sva (
	input wire logic CLK_I,
	input wire logic NRST_I,
	input wire logic HSEL_I,
	input wire logic [1:0] HTRANS_I,
	input wire logic HWRITE_I,
	input wire logic HREADY_I,
	input wire logic HREADYOUT_O,
	input wire logic HRESP_O,
	input wire logic SLEEP_I,
	input wire logic INTOSC_NO_CLKOUT_I,
	input wire logic WAKE_O,
	input wire logic LP_OSC_EN_O,
	input wire logic LCD_CLK_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!NRST_I);
	logic rd_take;
	logic wr_take;
	// Transfers accepted by the slave
	assign rd_take = HSEL_I & HTRANS_I[1] & HREADY_I & !HWRITE_I;
	assign wr_take = HSEL_I & HTRANS_I[1] & HREADY_I & HWRITE_I;
	////////////////////////////////////////////////////////////////////////////
	property p_okay; HRESP_O == 1'b0; endproperty
	a_okay: assert property (p_okay) else $error("bad response");
	property p_rd_wait; rd_take |=> !HREADYOUT_O ##1 HREADYOUT_O; endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("read wait");
	property p_wr_nowait; wr_take |=> HREADYOUT_O; endproperty
	a_wr_nowait: assert property (p_wr_nowait) else $error("write wait");
	property p_wait_cause; !HREADYOUT_O |-> $past(rd_take); endproperty
	a_wait_cause: assert property (p_wait_cause) else $error("stray wait");
	property p_no_two; !HREADYOUT_O |-> $past(HREADYOUT_O); endproperty
	a_no_two: assert property (p_no_two) else $error("long wait");
	property p_lpo; LP_OSC_EN_O |-> $past(INTOSC_NO_CLKOUT_I); endproperty
	a_lpo: assert property (p_lpo) else $error("osc on");
	property p_wake; WAKE_O |-> $past(SLEEP_I); endproperty
	a_wake: assert property (p_wake) else $error("wake awake");
	property p_lcd; LCD_CLK_O |-> $past(LP_OSC_EN_O); endproperty
	a_lcd: assert property (p_lcd) else $error("lcd clock");
endmodule
bind tmo_timer tmo_timer_sva u_sva (.CLK_I(CLK_I), .NRST_I(NRST_I), .HSEL_I(HSEL_I),
	.HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HREADY_I(HREADY_I),
	.HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O), .SLEEP_I(SLEEP_I),
	.INTOSC_NO_CLKOUT_I(INTOSC_NO_CLKOUT_I), .WAKE_O(WAKE_O),
	.LP_OSC_EN_O(LP_OSC_EN_O), .LCD_CLK_O(LCD_CLK_O));

// file: tmo_timer_tb.sv
// Self-checking bench of the gated timer
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
	$display("wrong value %s exp %0h got %0h", n, e, g); end end
module tmo_timer_tb;
	import tmo_pkg::*;
	logic clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0, go = 1'b0;
	logic gate = 1'b0, comp = 1'b0, sleep = 1'b0, intosc = 1'b0, lv;
	logic ext, hrdy, hresp, irq, wake, lpo, lcd;
	logic [1:0] htrans = 2'h0;
	logic [3:0] np = 4'h0;
	logic [15:0] c, d;
	tmo_word_t haddr = 32'h0, hwdata = 32'h0, hrdata, q;
	int errors = 0, n_tests = 0;
	// Clock of 100 ns
	always #50 clk = ~clk;
	tmo_timer dut (.CLK_I(clk), .NRST_I(nrst), .HSEL_I(hsel), .HADDR_I(haddr),
		.HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
		.HREADY_I(hrdy), .HREADYOUT_O(hrdy), .HRDATA_O(hrdata), .HRESP_O(hresp),
		.EXT_CLOCK_PIN_I(ext), .GATE_PIN_I(gate), .COMP_TWO_OUTPUT_I(comp),
		.SLEEP_I(sleep), .INTOSC_NO_CLKOUT_I(intosc), .IRQ_O(irq), .WAKE_O(wake),
		.LP_OSC_EN_O(lpo), .LCD_CLK_O(lcd));
	tmo_far_side far (.go_i(go), .n_i(np), .ext_o(ext));
	////////////////////////////////////////////////////////////////////////////
	task automatic final_report;
		$display("tests %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// Bounded wait for a rising edge that samples hready high
	task automatic rdy;
		int k;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (!hrdy && k < 20);
		if (!hrdy) begin
			errors++;
			final_report();
		end
	endtask
	// One single AHB transfer; read data lands in q
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, v};
		rdy();
		q = hrdata;
	endtask
	task automatic rd16;
		bus(1'b0, 8'h04, 8'h0);
		c[7:0] = q[7:0];
		bus(1'b0, 8'h08, 8'h0);
		c[15:8] = q[7:0];
	endtask
	// Preset, run for n clocks plus p external edges, stop, read back
	task automatic run(input logic [7:0] ctl, input logic [15:0] s, input int n,
		input logic [3:0] p);
		bus(1'b1, 8'h00, 8'h00);
		bus(1'b1, 8'h04, s[7:0]);
		bus(1'b1, 8'h08, s[15:8]);
		bus(1'b1, 8'h00, ctl);
		np <= p;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		repeat (n + 15 * p) @(posedge clk);
		bus(1'b1, 8'h00, 8'h00);
		rd16();
	endtask
	////////////////////////////////////////////////////////////////////////////
	task automatic t_regs;
		bus(1'b0, 8'h00, 8'h0);
		`CHK("ctrl", 32'h0, q)
		bus(1'b0, 8'h0C, 8'h0);
		`CHK("gsel", 32'h2, q)
		bus(1'b0, 8'h20, 8'h0);
		`CHK("unmapped", 32'h0, q)
		bus(1'b1, 8'h04, 8'h5A);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		bus(1'b0, 8'h04, 8'h0);
		`CHK("kept", 32'h5A, q)
		$display("regs done");
	endtask
	task automatic t_presc;
		for (int i = 0; i < 4; i++) begin
			run({2'h0, i[1:0], 4'h1}, 16'h0, 160, 4'h0);
			`CHK("presc", 1'b1, c + 1 >= (41 >> i) && c <= (41 >> i) + 1)
		end
		$display("presc done");
	endtask
	// Selected source at lv, the other one opposite, for each polarity
	task automatic t_gate;
		for (int i = 0; i < 8; i++) begin
			bus(1'b1, 8'h0C, {6'h0, i[1], 1'b0});
			lv = i[0] ~^ i[2];
			gate <= i[1] ? !lv : lv;
			comp <= i[1] ? lv : !lv;
			run({i[0], 7'h41}, 16'h0, 40, 4'h0);
			`CHK("gate", i[2], c != 16'h0)
		end
		run(8'h01, 16'h0, 40, 4'h0);
		`CHK("nogate", 1'b1, c != 16'h0)
		$display("gate done");
	endtask
	task automatic t_ovf;
		run(8'h01, 16'hFFFE, 20, 4'h0);
		d = c;
		`CHK("wrap", 1'b1, c < 16'h8)
		rd16();
		`CHK("hold", d, c)
		bus(1'b0, 8'h10, 8'h0);
		`CHK("flag", 32'h1, q)
		`CHK("irq", 1'b0, irq)
		bus(1'b1, 8'h14, 8'h01);
		bus(1'b1, 8'h18, 8'h03);
		repeat (2) @(negedge clk);
		`CHK("irq", 1'b1, irq)
		bus(1'b1, 8'h18, 8'h01);
		repeat (2) @(negedge clk);
		`CHK("irq", 1'b0, irq)
		bus(1'b1, 8'h10, 8'h00);
		bus(1'b0, 8'h10, 8'h0);
		`CHK("flag", 32'h0, q)
		$display("ovf done");
	endtask
	// Unsynchronised divide by 8; a counter write drops a partial prescale count
	task automatic t_pclr;
		run(8'h37, 16'h0, 8, 4'h6);
		`CHK("pclr", 16'h0, c)
		run(8'h37, 16'h0, 8, 4'h4);
		`CHK("pclr", 16'h0, c)
		run(8'h37, 16'h0, 8, 4'h9);
		`CHK("pclr", 16'h1, c)
		$display("pclr done");
	endtask
	// Sync and async external counting, awake and asleep
	task automatic t_ext;
		for (int i = 0; i < 4; i++) begin
			sleep <= i[1];
			run({5'h0, i[0], 2'h3}, 16'h0, 8, 4'h5);
			`CHK("ext", (i == 2) ? 16'h0 : 16'h4, c)
		end
		$display("ext done");
	endtask
	// Overflow enable and peripheral enable still set, global enable clear
	task automatic t_wake;
		run(8'h07, 16'hFFFF, 8, 4'h2);
		`CHK("wrap", 16'h0, c)
		bus(1'b1, 8'h00, 8'h07);
		repeat (2) @(negedge clk);
		`CHK("wake", 1'b1, wake)
		`CHK("irq", 1'b0, irq)
		@(posedge clk);
		sleep <= 1'b0;
		repeat (2) @(negedge clk);
		`CHK("wake", 1'b0, wake)
		$display("wake done");
	endtask
	task automatic t_osc;
		for (int i = 0; i < 2; i++) begin
			@(posedge clk);
			intosc <= i[0];
			bus(1'b1, 8'h00, 8'h08);
			repeat (2) @(negedge clk);
			`CHK("lpo", i[0], lpo)
		end
		bus(1'b1, 8'h1C, 8'h01);
		np <= 4'h1;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		repeat (11) @(negedge clk);
		`CHK("lcd", 1'b1, lcd)
		$display("osc done");
	endtask
	// Main sequence
	initial begin
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		t_regs();
		t_presc();
		t_gate();
		t_ovf();
		t_ext();
		t_wake();
		t_pclr();
		t_osc();
		final_report();
	end
endmodule
